// ==== logic/rmc_act_led.sv ====
// Purpose: activity blinker for one front indicator
// Assumes: act is a one-cycle pulse per frame
// Notes:   each pulse restarts a lit period of HOLD_CYC cycles
`timescale 1ns/1ps
module rmc_act_led #(
  parameter int unsigned HOLD_CYC = 10000000
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // event and indicator
  input  wire logic act,
  output logic      led
);

  logic [31:0] hold_cnt;

  // ----------------------------------------------------------------
  // hold counter: a busy bus keeps restarting it, so the lamp
  // flickers only between frames rather than per byte
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_cnt <= 32'h0;
    end else if (act) begin
      hold_cnt <= HOLD_CYC[31:0];
    end else if (hold_cnt != 32'h0) begin
      hold_cnt <= hold_cnt - 32'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      led <= 1'b0;
    end else begin
      led <= act || (hold_cnt > 32'h1);
    end
  end

endmodule // rmc_act_led

// ==== logic/rmc_map.svh ====
// Purpose: register addresses, command codes and timing figures of the relay command block
// Assumes: register addresses are the zero-based link register numbers
// Notes:   definitions only
`ifndef RMC_MAP_SVH
`define RMC_MAP_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define RMC_ADDR_COMMAND_WORD   16'h9CB9
`define RMC_ADDR_CAL_NAME_LOW   16'h9CBC
`define RMC_ADDR_CAL_NAME_MID   16'h9CBD
`define RMC_ADDR_CAL_NAME_HIGH  16'h9CBE
`define RMC_ADDR_HW_REVISION    16'h9CBF

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RMC_RST_COMMAND_WORD    16'h0000
`define RMC_RST_CAL_NAME        16'h0000
`define RMC_RST_HW_REVISION     16'h0000

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define RMC_CMD_NONE            16'h0000
`define RMC_CMD_STORE_CAL       16'hC1B0
`define RMC_CMD_STORE_SETT      16'hC1C0
`define RMC_CMD_RELOAD_SW       16'hD166
`define RMC_CMD_RESET           16'hC1A0

// ----------------------------------------------------------------
// function codes and exception answers
// ----------------------------------------------------------------
`define RMC_FC_READ_MULTI       8'h03
`define RMC_FC_WRITE_SINGLE     8'h06
`define RMC_FC_WRITE_MULTI      8'h10
`define RMC_EXC_NONE            8'h00
`define RMC_EXC_BAD_FUNCTION    8'h01
`define RMC_EXC_BAD_ADDRESS     8'h02

// ----------------------------------------------------------------
// front switch fields
// ----------------------------------------------------------------
`define RMC_SW_ADDR_MSB         5
`define RMC_SW_BAUD_LSB         6
`define RMC_SW_NONE             8'h00
`define RMC_BAUD_SW0            3'h3
`define RMC_BAUD_SW1            3'h4
`define RMC_BAUD_SW2            3'h5
`define RMC_BAUD_SW3            3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RMC_MCLK_KHZ            200000
`define RMC_ACT_HOLD_MS         50
`define RMC_FAIL_BLINK_MS       250

`endif

// ==== logic/rmc_pkg.sv ====
// Purpose: types of the relay command block
// Assumes: nothing
// Notes:   figures live in rmc_map.svh
package rmc_pkg;

  // one register access handed in by the frame engine
  typedef struct packed {
    logic [7:0]  fcode;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rmc_req_t;

  // answer to one register access
  typedef struct packed {
    logic [15:0] rdata;
    logic [7:0]  exc;
  } rmc_rsp_t;

  // configuration in use by the link
  typedef struct packed {
    logic [7:0] node_addr;
    logic [2:0] baud_code;
  } rmc_link_cfg_t;

endpackage

// ==== logic/rmc_relay_cmd.sv ====
// Purpose: command register, configuration source and front indicators of an
//          eight-relay serial slave
// Assumes: frame engine hands in one register access per req pulse, synchronous
//          to mclk; fcode checked here, crc and node match checked upstream
// Notes:   nonvolatile store and soft reset are requested as pulses only
`timescale 1ns/1ps

`include "rmc_map.svh"

// Function
// RQ1 - writing C1B0 stores calibration; C1C0 stores settings to nonvolatile memory
// RQ2 - writing D166 rereads switches; C1A0 resets; command register resets to zero
// RQ3 - all switches zero selects stored address and baud, else switch values
// RQ4 - switches reach node addresses 0 to 63 only; higher need stored configuration
// RQ5 - baud rates outside the switch set only come from stored configuration
// RQ6 - fail indicator lit while any fail event is active
// RQ7 - receive and transmit indicators blink while frames are exchanged
// RQ8 - each output indicator lit exactly when its relay output is active
// RQ9 - fail indicator blinks intermittently during a firmware update
// RQ10 - a firmware update leaves stored configuration unchanged
// RQ11 - only function codes 3, 6 and 16 are accepted
// RQ12 - unknown command values do nothing; register returns to zero after execution
// RQ13 - switches sampled at reset and on reread command, sampled value used
module rmc_relay_cmd
  import rmc_pkg::*;
#(
  parameter int unsigned ACT_HOLD_CYC   = `RMC_ACT_HOLD_MS * `RMC_MCLK_KHZ,
  parameter int unsigned FAIL_BLINK_CYC = `RMC_FAIL_BLINK_MS * `RMC_MCLK_KHZ
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // register access from the frame engine
  input  wire logic          req,
  input  wire rmc_req_t      req_data,
  output logic               rsp_valid,
  output rmc_rsp_t           rsp_data,
  // front switches and stored configuration
  input  wire logic [7:0]    switch_in,
  input  wire rmc_link_cfg_t stored_cfg,
  output rmc_link_cfg_t      link_cfg,
  output logic               cfg_from_switch,
  // command requests to the rest of the node
  output logic               store_calibration_cmd,
  output logic               store_settings_cmd,
  output logic               reload_switches_cmd,
  output logic               soft_reset_req,
  // status of the node
  input  wire logic [7:0]    fail_events,
  input  wire logic          fw_update_active,
  input  wire logic          frame_rx,
  input  wire logic          frame_tx,
  input  wire logic [7:0]    relay_out,
  // front indicators
  output logic               led_fail,
  output logic               led_rx,
  output logic               led_tx,
  output logic [7:0]         output_indicators
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] command_word;
  logic [15:0] cal_name_low;
  logic [15:0] cal_name_mid;
  logic [15:0] cal_name_high;
  logic [15:0] hardware_revision;
  logic [7:0]  switch_sample;
  logic        sample_pending;
  logic [31:0] blink_cnt;
  logic        blink_phase;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic        fc_read;
  logic        fc_write;
  logic        addr_hit;
  logic        wr_en;
  logic [15:0] next_rdata;
  logic [7:0]  next_exc;

  assign fc_read  = (req_data.fcode == `RMC_FC_READ_MULTI);
  assign fc_write = (req_data.fcode == `RMC_FC_WRITE_SINGLE) ||
                    (req_data.fcode == `RMC_FC_WRITE_MULTI);

  always_comb begin
    addr_hit   = 1'b1;
    next_rdata = 16'h0000;
    case (req_data.addr)
      `RMC_ADDR_COMMAND_WORD:  next_rdata = command_word;
      `RMC_ADDR_CAL_NAME_LOW:  next_rdata = cal_name_low;
      `RMC_ADDR_CAL_NAME_MID:  next_rdata = cal_name_mid;
      `RMC_ADDR_CAL_NAME_HIGH: next_rdata = cal_name_high;
      `RMC_ADDR_HW_REVISION:   next_rdata = hardware_revision;
      default:                 addr_hit   = 1'b0;
    endcase
  end

  // function code is judged before the address, as the link expects
  always_comb begin
    if (!(fc_read || fc_write)) begin
      next_exc = `RMC_EXC_BAD_FUNCTION; // [RQ11]
    end else if (!addr_hit) begin
      next_exc = `RMC_EXC_BAD_ADDRESS;
    end else begin
      next_exc = `RMC_EXC_NONE;
    end
  end

  assign wr_en = req && fc_write && addr_hit; // [RQ11]

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= req;
      if (req) begin
        rsp_data.exc   <= next_exc;
        rsp_data.rdata <= (fc_read && addr_hit) ? next_rdata : 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // command register
  // ----------------------------------------------------------------
  // a new write in the clearing cycle wins, so no command is lost
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      command_word <= `RMC_RST_COMMAND_WORD; // [RQ2]
    end else if (wr_en && req_data.addr == `RMC_ADDR_COMMAND_WORD) begin
      command_word <= req_data.wdata;
    end else begin
      command_word <= `RMC_CMD_NONE; // [RQ12]
    end
  end

  // stores are withheld during an update so the loader cannot
  // overwrite the configuration in nonvolatile memory
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      store_calibration_cmd <= 1'b0;
      store_settings_cmd    <= 1'b0;
      reload_switches_cmd   <= 1'b0;
      soft_reset_req        <= 1'b0;
    end else begin
      store_calibration_cmd <= 1'b0;
      store_settings_cmd    <= 1'b0;
      reload_switches_cmd   <= 1'b0;
      soft_reset_req        <= 1'b0;
      case (command_word)
        `RMC_CMD_STORE_CAL:  store_calibration_cmd <= !fw_update_active; // [RQ1] [RQ10]
        `RMC_CMD_STORE_SETT: store_settings_cmd    <= !fw_update_active; // [RQ1] [RQ10]
        `RMC_CMD_RELOAD_SW:  reload_switches_cmd   <= 1'b1; // [RQ2]
        `RMC_CMD_RESET:      soft_reset_req        <= 1'b1; // [RQ2]
        default:             soft_reset_req        <= 1'b0; // [RQ12]
      endcase
    end
  end

  // ----------------------------------------------------------------
  // calibration name and hardware revision
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cal_name_low  <= `RMC_RST_CAL_NAME;
      cal_name_mid  <= `RMC_RST_CAL_NAME;
      cal_name_high <= `RMC_RST_CAL_NAME;
    end else if (wr_en) begin
      if (req_data.addr == `RMC_ADDR_CAL_NAME_LOW) begin
        cal_name_low <= req_data.wdata;
      end
      if (req_data.addr == `RMC_ADDR_CAL_NAME_MID) begin
        cal_name_mid <= req_data.wdata;
      end
      if (req_data.addr == `RMC_ADDR_CAL_NAME_HIGH) begin
        cal_name_high <= req_data.wdata;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hardware_revision <= `RMC_RST_HW_REVISION;
    end else if (wr_en && req_data.addr == `RMC_ADDR_HW_REVISION) begin
      hardware_revision <= req_data.wdata;
    end
  end

  // ----------------------------------------------------------------
  // switch sampling
  // ----------------------------------------------------------------
  // the reset value cannot be a port, so the first clocked cycle
  // after release takes the sample
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sample_pending <= 1'b1;
    end else begin
      sample_pending <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      switch_sample <= `RMC_SW_NONE;
    end else if (sample_pending || reload_switches_cmd) begin
      switch_sample <= switch_in; // [RQ13]
    end
  end

  // ----------------------------------------------------------------
  // configuration source
  // ----------------------------------------------------------------
  logic [2:0] sw_baud;

  // only four codes are reachable from the switches
  always_comb begin
    case (switch_sample[7:`RMC_SW_BAUD_LSB])
      2'h0:    sw_baud = `RMC_BAUD_SW0;
      2'h1:    sw_baud = `RMC_BAUD_SW1;
      2'h2:    sw_baud = `RMC_BAUD_SW2;
      2'h3:    sw_baud = `RMC_BAUD_SW3;
      default: sw_baud = `RMC_BAUD_SW0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_from_switch <= 1'b0;
      link_cfg        <= '0;
    end else if (switch_sample == `RMC_SW_NONE) begin
      cfg_from_switch <= 1'b0;
      link_cfg        <= stored_cfg; // [RQ3]
    end else begin
      cfg_from_switch    <= 1'b1; // [RQ3]
      link_cfg.node_addr <= {2'b00, switch_sample[`RMC_SW_ADDR_MSB:0]}; // [RQ4]
      link_cfg.baud_code <= sw_baud; // [RQ5]
    end
  end

  // ----------------------------------------------------------------
  // fail indicator
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      blink_cnt   <= 32'h0;
      blink_phase <= 1'b0;
    end else if (!fw_update_active) begin
      blink_cnt   <= 32'h0;
      blink_phase <= 1'b0;
    end else if (blink_cnt >= FAIL_BLINK_CYC - 1) begin
      blink_cnt   <= 32'h0;
      blink_phase <= !blink_phase; // [RQ9]
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // update blink overrides fail events: the node is not running then
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      led_fail <= 1'b0;
    end else if (fw_update_active) begin
      led_fail <= !blink_phase; // [RQ9]
    end else begin
      led_fail <= |fail_events; // [RQ6]
    end
  end

  // ----------------------------------------------------------------
  // output indicators
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_out_led
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          output_indicators[gi] <= 1'b0;
        end else begin
          output_indicators[gi] <= relay_out[gi]; // [RQ8]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // activity indicators
  // ----------------------------------------------------------------
  rmc_act_led #(
    .HOLD_CYC (ACT_HOLD_CYC)
  ) u_rx_led (
    .mclk (mclk),
    .rst  (rst),
    .act  (frame_rx), // [RQ7]
    .led  (led_rx)
  );

  rmc_act_led #(
    .HOLD_CYC (ACT_HOLD_CYC)
  ) u_tx_led (
    .mclk (mclk),
    .rst  (rst),
    .act  (frame_tx), // [RQ7]
    .led  (led_tx)
  );

endmodule // rmc_relay_cmd

// ==== test/rmc_master_model.sv ====
// Purpose: serial bus master issuing single register accesses
// Assumes: answer is registered on the take edge and read 1 ns after it, never stalls
// Notes:   request lines inverted while idle so stale values never match
`timescale 1ns/1ps
module rmc_master_model
  import rmc_pkg::*;
(
  // clock
  input  wire logic     mclk,
  // register access
  output logic          req,
  output rmc_req_t      req_data,
  input  wire logic     rsp_valid,
  input  wire rmc_rsp_t rsp_data
);
  // ----------------------------------------------------------------
  // access task
  // ----------------------------------------------------------------
  initial begin
    req      = 1'b0;
    req_data = '0;
  end

  // function codes 3, 6, 16 and command codes come from the caller
  task automatic xfer(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] d,
                      output rmc_rsp_t r, output logic ok);
    @(posedge mclk);
    #1;
    req      = 1'b1;
    req_data = '{fcode: fc, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    req      = 1'b0;
    req_data = ~req_data;
    ok       = rsp_valid;
    r        = rsp_data;
  endtask
endmodule // rmc_master_model

// ==== test/rmc_relay_cmd_props.sv ====
// Purpose: port-level checker for the relay command block
// Assumes: one clock domain, reset active high
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module rmc_relay_cmd_props
  import rmc_pkg::*;
#(
  parameter int unsigned ACT_HOLD_CYC   = 8,
  parameter int unsigned FAIL_BLINK_CYC = 16
) (
  // clock and reset
  input wire logic          mclk,
  input wire logic          rst,
  // register access
  input wire logic          req,
  input wire rmc_req_t      req_data,
  input wire logic          rsp_valid,
  input wire rmc_rsp_t      rsp_data,
  // configuration and commands
  input wire rmc_link_cfg_t link_cfg,
  input wire logic          cfg_from_switch,
  input wire logic          store_calibration_cmd,
  input wire logic          store_settings_cmd,
  input wire logic          reload_switches_cmd,
  input wire logic          soft_reset_req,
  // status and indicators
  input wire logic [7:0]    fail_events,
  input wire logic          fw_update_active,
  input wire logic          frame_rx,
  input wire logic [7:0]    relay_out,
  input wire logic          led_fail,
  input wire logic          led_rx,
  input wire logic [7:0]    output_indicators
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic wr_cmd;
  assign wr_cmd = req && req_data.fcode == 8'h06 && req_data.addr == 16'h9CB9;

  a_rsp_timely: assert property (req |=> rsp_valid)
    else $error("no answer one cycle after a request");
  a_bad_fcode: assert property (req && !(req_data.fcode inside {8'h03, 8'h06, 8'h10})
    |=> rsp_data.exc == 8'h01) else $error("unsupported function not refused");
  a_store_cal: assert property (wr_cmd && req_data.wdata == 16'hC1B0 && !fw_update_active
    |=> ##1 store_calibration_cmd) else $error("calibration store missing");
  a_store_sett: assert property (wr_cmd && req_data.wdata == 16'hC1C0 && !fw_update_active
    |=> ##1 store_settings_cmd) else $error("settings store missing");
  a_reload_sw: assert property (wr_cmd && req_data.wdata == 16'hD166
    |=> ##1 reload_switches_cmd) else $error("switch reload missing");
  a_soft_reset: assert property (wr_cmd && req_data.wdata == 16'hC1A0
    |=> ##1 soft_reset_req) else $error("reset request missing");
  a_unknown_cmd: assert property (wr_cmd && !(req_data.wdata inside
    {16'hC1B0, 16'hC1C0, 16'hD166, 16'hC1A0}) |=> ##1 !(store_calibration_cmd ||
    store_settings_cmd || reload_switches_cmd || soft_reset_req))
    else $error("unknown command acted on");
  a_out_leds: assert property (!$past(rst) |-> output_indicators == $past(relay_out))
    else $error("output indicators differ from relays");
  a_fail_led: assert property (!$past(rst) && !$past(fw_update_active)
    |-> led_fail == (|$past(fail_events))) else $error("fail indicator wrong");
  a_rx_led: assert property (frame_rx |=> led_rx) else $error("rx indicator dark");
  a_sw_addr: assert property (cfg_from_switch |-> link_cfg.node_addr[7:6] == 2'b00)
    else $error("switch address above 63");
  a_sw_baud: assert property (cfg_from_switch |-> link_cfg.baud_code inside
    {3'h3, 3'h4, 3'h5, 3'h7}) else $error("switch baud outside set");
  a_fw_blink: assert property ($rose(fw_update_active) |=> led_fail [*8])
    else $error("fail indicator not lit on update start");
endmodule // rmc_relay_cmd_props

// ==== test/rmc_relay_cmd_tb.sv ====
// Purpose: self-checking testbench of the relay command block
// Assumes: short indicator counts, 8 and 16 cycles
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module rmc_relay_cmd_tb import rmc_pkg::*;;
  logic          mclk = 1'b0;
  logic          rst = 1'b1;
  logic          req, rsp_valid, cfg_from_switch, fw_update_active, frame_rx, frame_tx;
  logic          led_fail, led_rx, led_tx, ok, st_cal, st_set, rl_sw, sr_req;
  logic [7:0]    switch_in, fail_events, relay_out, output_indicators;
  rmc_req_t      req_data;
  rmc_rsp_t      rsp_data, r;
  rmc_link_cfg_t stored_cfg, link_cfg;
  int            fail_count, comparisons;

  always #2.5 mclk = ~mclk;

  rmc_relay_cmd #(.ACT_HOLD_CYC(8), .FAIL_BLINK_CYC(16)) i_dut (
    .mclk(mclk), .rst(rst), .req(req), .req_data(req_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .switch_in(switch_in), .stored_cfg(stored_cfg),
    .link_cfg(link_cfg), .cfg_from_switch(cfg_from_switch), .store_calibration_cmd(st_cal),
    .store_settings_cmd(st_set), .reload_switches_cmd(rl_sw), .soft_reset_req(sr_req),
    .fail_events(fail_events), .fw_update_active(fw_update_active), .frame_rx(frame_rx),
    .frame_tx(frame_tx), .relay_out(relay_out), .led_fail(led_fail), .led_rx(led_rx),
    .led_tx(led_tx), .output_indicators(output_indicators));

  rmc_master_model i_mst (.mclk(mclk), .req(req), .req_data(req_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    i_mst.xfer(8'h03, a, 16'h0000, r, ok);
    `CHK("read answer", 1'b1, ok)
    `CHK("read data", e, r.rdata)
  endtask

  // pulses seen as {calibration, settings, reload, reset}
  task automatic cmd(input logic [15:0] c, input logic [3:0] e);
    i_mst.xfer(8'h06, 16'h9CB9, c, r, ok);
    @(posedge mclk);
    #1;
    `CHK("command pulses", e, {st_cal, st_set, rl_sw, sr_req})
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {switch_in, fail_events, relay_out, fw_update_active, frame_rx, frame_tx} = '0;
    stored_cfg = '{8'h5A, 3'h6};
    tick(4);
    rst = 1'b0;
    rd(16'h9CB9, 16'h0000);
    cmd(16'hC1B0, 4'b1000);
    cmd(16'hC1C0, 4'b0100);
    cmd(16'hD166, 4'b0010);
    cmd(16'hC1A0, 4'b0001);
    cmd(16'h1234, 4'b0000);
    rd(16'h9CB9, 16'h0000);
    i_mst.xfer(8'h10, 16'h9CBF, 16'hBEEF, r, ok);
    rd(16'h9CBF, 16'hBEEF);
    i_mst.xfer(8'h04, 16'h9CB9, 16'hC1C0, r, ok);
    `CHK("bad function", 8'h01, r.exc)
    tick(1);
    `CHK("refused store", 1'b0, st_set)
    i_mst.xfer(8'h06, 16'h9CBA, 16'h0001, r, ok);
    `CHK("bad address", 8'h02, r.exc)
    `CHK("stored config", {8'h5A, 3'h6}, link_cfg)
    switch_in = 8'hC5;
    tick(4);
    `CHK("unsampled switches", 1'b0, cfg_from_switch)
    cmd(16'hD166, 4'b0010);
    tick(2);
    `CHK("switch config", {1'b1, 8'h05, 3'h7}, {cfg_from_switch, link_cfg})
    switch_in = 8'h7F;
    cmd(16'hD166, 4'b0010);
    tick(2);
    `CHK("top switch address", {8'h3F, 3'h4}, link_cfg)
    switch_in = 8'h00;
    cmd(16'hD166, 4'b0010);
    stored_cfg = '{8'h40, 3'h1};
    tick(2);
    `CHK("back to stored", {1'b0, 8'h40, 3'h1}, {cfg_from_switch, link_cfg})
    relay_out = 8'hA5;
    fail_events = 8'h10;
    frame_rx = 1'b1;
    frame_tx = 1'b1;
    tick(1);
    {frame_rx, frame_tx} = 2'b00;
    `CHK("outputs", 8'hA5, output_indicators)
    `CHK("fail lit", 1'b1, led_fail)
    `CHK("activity lit", 2'b11, {led_rx, led_tx})
    fail_events = 8'h00;
    tick(10);
    `CHK("activity dark", 2'b00, {led_rx, led_tx})
    `CHK("fail dark", 1'b0, led_fail)
    fw_update_active = 1'b1;
    tick(2);
    `CHK("update lit", 1'b1, led_fail)
    cmd(16'hC1C0, 4'b0000);
    tick(16);
    `CHK("update blink", 1'b0, led_fail)
    fw_update_active = 1'b0;
    tick(2);
    // a mid-run reset must take a fresh switch sample
    switch_in = 8'h42;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(3);
    `CHK("switches at reset", {1'b1, 8'h02, 3'h4}, {cfg_from_switch, link_cfg})
    rd(16'h9CB9, 16'h0000);
    finish_test();
  end

  // bounded run: the sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    $display("ERROR watchdog expired");
    finish_test();
  end
endmodule // rmc_relay_cmd_tb

bind rmc_relay_cmd rmc_relay_cmd_props #(.ACT_HOLD_CYC(ACT_HOLD_CYC),
  .FAIL_BLINK_CYC(FAIL_BLINK_CYC)) i_props (.mclk(mclk), .rst(rst), .req(req),
  .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link_cfg(link_cfg),
  .cfg_from_switch(cfg_from_switch), .store_calibration_cmd(store_calibration_cmd),
  .store_settings_cmd(store_settings_cmd), .reload_switches_cmd(reload_switches_cmd),
  .soft_reset_req(soft_reset_req), .fail_events(fail_events),
  .fw_update_active(fw_update_active), .frame_rx(frame_rx), .relay_out(relay_out),
  .led_fail(led_fail), .led_rx(led_rx), .output_indicators(output_indicators));
